// ==== include/pwm_pkg.sv ====
package pwm_pkg;
    localparam int CH_NUM = 4;
    localparam int DIV_W = 12;
    localparam int DUTY_W = DIV_W + 1;
    localparam int PAT_W = 20;
    localparam int RCNT_W = 5;
    localparam logic [RCNT_W-1:0] RHY_LAST = 5'h13;
    localparam longint CLK_HZ = 10000000;
    localparam longint RHYTHM_TICK_MS = 50;
    localparam int RHYTHM_TICK_CYC = int'((RHYTHM_TICK_MS * CLK_HZ) / 1000);
    localparam int TICK_CNT_W = 24;
    localparam logic [DIV_W-1:0] DIV_RST = 12'h000;
    localparam logic [RCNT_W-1:0] RCNT_RST = RHY_LAST;
endpackage

// ==== include/pwm_ch_if.sv ====
`timescale 1ns/10ps
// one channel's configuration going down and its raw wave coming back
interface pwm_ch_if;
    import pwm_pkg::*;
    logic src_fast;
    logic [DIV_W-1:0] pre;
    logic [DIV_W-1:0] period;
    logic [DUTY_W-1:0] duty;
    logic enable;
    logic restart;
    logic tick_fast;
    logic tick_slow;
    logic wave;
    logic at_wrap;
    modport top (output src_fast, pre, period, duty, enable, restart, tick_fast, tick_slow, input wave, at_wrap);
    modport ch (input src_fast, pre, period, duty, enable, restart, tick_fast, tick_slow, output wave, at_wrap);
endinterface

// ==== rtl/pwm_channel.sv ====
`timescale 1ns/10ps
module pwm_channel
    import pwm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    pwm_ch_if.ch cfg
);
    logic [DIV_W-1:0] pre_cnt_r;
    logic [DIV_W-1:0] cnt_r;
    logic wave_r;
    logic fast_step;
    logic step;
    logic hold;

    ////////////////////////////////////////////////////////////////////////
    // step selection: prescaler only in the fast path
    assign fast_step = cfg.tick_fast && (pre_cnt_r == DIV_RST);
    assign step = cfg.src_fast ? fast_step : cfg.tick_slow;
    assign hold = cfg.restart || !cfg.enable;
    assign cfg.wave = wave_r;
    assign cfg.at_wrap = step && (cnt_r >= cfg.period);

    // prescaler counts fast ticks down, reloading from the setting
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre_cnt_r <= DIV_RST;
        end else if (hold || !cfg.src_fast) begin
            pre_cnt_r <= cfg.pre;
        end else if (cfg.tick_fast) begin
            pre_cnt_r <= fast_step ? cfg.pre : pre_cnt_r - 12'h001;
        end
    end

    // period counter; period 0 would stall at zero so one tick is the shortest cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= DIV_RST;
        end else if (hold) begin
            cnt_r <= DIV_RST;
        end else if (step) begin
            cnt_r <= (cnt_r >= cfg.period) ? DIV_RST : cnt_r + 12'h001;
        end
    end

    // wave is high while the count sits below duty; lags the count by one clock.
    // duty above the period forces high, so a period shrunk below a stale count cannot drop the wave
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wave_r <= 1'b0;
        end else begin
            wave_r <= cfg.enable && (({1'b0, cnt_r} < cfg.duty) || (cfg.duty > {1'b0, cfg.period}));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_restart_zero;
        cfg.restart |=> cnt_r == DIV_RST;
    endproperty
    a_restart_zero: assert property (p_restart_zero) else $error("count not cleared by restart");

    property p_duty_zero;
        cfg.duty == 13'h0000 |=> !wave_r;
    endproperty
    a_duty_zero: assert property (p_duty_zero) else $error("wave high at zero duty");

    property p_duty_full;
        cfg.enable && (cfg.duty > {1'b0, cfg.period}) |=> wave_r;
    endproperty
    a_duty_full: assert property (p_duty_full) else $error("wave low at full duty");

    property p_wrap;
        cfg.enable && !cfg.restart && step && (cnt_r >= cfg.period) |=> cnt_r == DIV_RST;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not wrap at period");

    property p_slow_step;
        cfg.enable && !cfg.restart && !cfg.src_fast && cfg.tick_slow && (cnt_r < cfg.period)
            |=> cnt_r == $past(cnt_r) + 12'h001;
    endproperty
    a_slow_step: assert property (p_slow_step) else $error("slow tick did not advance count");

    property p_fast_gated;
        cfg.enable && !cfg.restart && cfg.src_fast && (pre_cnt_r != DIV_RST) |=> cnt_r == $past(cnt_r);
    endproperty
    a_fast_gated: assert property (p_fast_gated) else $error("count moved before prescaler expired");
endmodule

// ==== rtl/pwm_pulse_rhythm_unit.sv ====
`timescale 1ns/10ps
module pwm_pulse_rhythm_unit
    import pwm_pkg::*;
#(
    parameter int RHYTHM_TICK_CYCLES = RHYTHM_TICK_CYC
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic tick_fast,
    input wire logic tick_slow,
    input wire logic [CH_NUM-1:0] ch_enable,
    input wire logic [CH_NUM-1:0] src_fast,
    input wire logic [CH_NUM-1:0][DIV_W-1:0] prescale,
    input wire logic [CH_NUM-1:0][DIV_W-1:0] period,
    input wire logic [CH_NUM-1:0][DUTY_W-1:0] duty,
    input wire logic [CH_NUM-1:0] invert,
    input wire logic [CH_NUM-1:0] mask_enable,
    input wire logic [CH_NUM-1:0] mask_level,
    input wire logic [CH_NUM-1:0][PAT_W-1:0] pattern,
    input wire logic sync_strobe,
    input wire logic [CH_NUM-1:0] sync_select,
    input wire logic rhythm_run,
    input wire logic rhythm_event_enable,
    output logic [CH_NUM-1:0] pwm_out,
    output logic [RCNT_W-1:0] rhythm_count,
    output logic rhythm_event
);
    logic [TICK_CNT_W-1:0] tick_cnt_r;
    logic rhythm_tick;
    logic [RCNT_W-1:0] rcnt_r;
    logic [RCNT_W-1:0] rcnt_nxt;
    logic event_r;
    logic [CH_NUM-1:0] out_r;
    logic [CH_NUM-1:0] out_nxt;
    logic [CH_NUM-1:0] masked;
    logic [CH_NUM-1:0] wave;
    logic [CH_NUM-1:0] wrap;

    localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(RHYTHM_TICK_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // channels: one interface and one generator each
    for (genvar i = 0; i < CH_NUM; i++) begin : g_ch
        pwm_ch_if u_if ();
        assign u_if.src_fast = src_fast[i];
        assign u_if.pre = prescale[i];
        assign u_if.period = period[i];
        assign u_if.duty = duty[i];
        assign u_if.enable = ch_enable[i];
        assign u_if.restart = sync_strobe && sync_select[i];
        assign u_if.tick_fast = tick_fast;
        assign u_if.tick_slow = tick_slow;
        assign wave[i] = u_if.wave;
        assign wrap[i] = u_if.at_wrap;

        pwm_channel u_ch (
            .clk (clk),
            .nrst (nrst),
            .cfg (u_if.ch)
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // rhythm time base from the system clock, free of any channel state
    assign rhythm_tick = rhythm_run && (tick_cnt_r == TICK_LAST);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_r <= '0;
        end else if (!rhythm_run || rhythm_tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 24'h000001;
        end
    end

    // down counter; stopping the run holds the index so the pattern can freeze
    always_comb begin
        rcnt_nxt = rcnt_r;
        if (rhythm_tick) begin
            rcnt_nxt = (rcnt_r == '0) ? RHY_LAST : rcnt_r - 5'h01;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rcnt_r <= RCNT_RST;
        end else begin
            rcnt_r <= rcnt_nxt;
        end
    end

    // one pulse per pattern period, at the reload
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            event_r <= 1'b0;
        end else begin
            event_r <= rhythm_event_enable && rhythm_tick && (rcnt_r == '0);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mask and polarity; the mask level wins over inversion, so a masked
    // output always shows the chosen level whatever the polarity setting
    always_comb begin
        for (int i = 0; i < CH_NUM; i++) begin
            masked[i] = mask_enable[i] && !pattern[i][rcnt_r];
            out_nxt[i] = masked[i] ? mask_level[i] : (wave[i] ^ invert[i]);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_r <= '0;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign pwm_out = out_r;
    assign rhythm_count = rcnt_r;
    assign rhythm_event = event_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_reload;
        rhythm_tick && (rcnt_r == 5'h00) |=> rcnt_r == 5'h13;
    endproperty
    a_reload: assert property (p_reload) else $error("rhythm count did not reload to 19");

    property p_count_down;
        rhythm_tick && (rcnt_r != 5'h00) |=> rcnt_r == $past(rcnt_r) - 5'h01;
    endproperty
    a_count_down: assert property (p_count_down) else $error("rhythm count did not step down");

    property p_count_hold;
        !rhythm_tick |=> rcnt_r == $past(rcnt_r);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("rhythm count moved without a tick");

    property p_range;
        rcnt_r <= 5'h13;
    endproperty
    a_range: assert property (p_range) else $error("rhythm count out of range");

    property p_event_cause;
        event_r |-> $past(rhythm_tick) && (rcnt_r == 5'h13) && $past(rhythm_event_enable);
    endproperty
    a_event_cause: assert property (p_event_cause) else $error("rhythm event without a wrap");

    property p_event_due;
        rhythm_event_enable && rhythm_tick && (rcnt_r == 5'h00) |=> event_r ##1 !event_r;
    endproperty
    a_event_due: assert property (p_event_due) else $error("rhythm event missing or too long");

    property p_tick_spacing;
        rhythm_tick |=> !rhythm_tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("rhythm ticks back to back");

    for (genvar i = 0; i < CH_NUM; i++) begin : g_chk
        property p_mask_level;
            mask_enable[i] && !pattern[i][rcnt_r] |=> pwm_out[i] == $past(mask_level[i]);
        endproperty
        a_mask_level: assert property (p_mask_level) else $error("masked output not at chosen level");

        property p_polarity;
            !(mask_enable[i] && !pattern[i][rcnt_r]) |=> pwm_out[i] == ($past(wave[i]) ^ $past(invert[i]));
        endproperty
        a_polarity: assert property (p_polarity) else $error("output does not follow wave polarity");
    end

    c_wrap_event: cover property (rhythm_tick && (rcnt_r == 5'h00) ##1 event_r);
    c_masked: cover property (mask_enable[0] && !pattern[0][rcnt_r] ##1 pwm_out[0] == mask_level[0]);
    c_sync_all: cover property (sync_strobe && (sync_select == 4'hf));
    c_pwm_wrap: cover property (wrap[0] && src_fast[0]);
endmodule

// ==== sim/led_load.sv ====
`timescale 1ns/10ps
// led or buzzer load: tallies lit cycles and turn-on edges of each channel
module led_load
    import pwm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic clr,
    input wire logic [CH_NUM-1:0] drive,
    output logic [CH_NUM-1:0][15:0] lit,
    output logic [CH_NUM-1:0][15:0] rises
);
    logic [CH_NUM-1:0] prev_r;
    // a lamp only sees levels; clr restarts the tallies so windows hold whole periods
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_r <= '0;
            lit <= '0;
            rises <= '0;
        end else begin
            prev_r <= drive;
            for (int i = 0; i < CH_NUM; i++) begin
                lit[i] <= clr ? 16'h0000 : lit[i] + 16'(drive[i]);
                rises[i] <= clr ? 16'h0000 : rises[i] + 16'(drive[i] & ~prev_r[i]);
            end
        end
    end
endmodule

// ==== sim/pwm_pulse_rhythm_unit_bench.sv ====
`timescale 1ns/10ps
module pwm_pulse_rhythm_unit_bench;
    import pwm_pkg::*;
    localparam int TK = 4;
    logic clk, nrst, tick_fast, tick_slow, sync_strobe, rhythm_run, rhythm_event_enable, clr, rhythm_event;
    logic [CH_NUM-1:0] ch_enable, src_fast, invert, mask_enable, mask_level, sync_select, pwm_out;
    logic [CH_NUM-1:0][DIV_W-1:0] prescale, period;
    logic [CH_NUM-1:0][DUTY_W-1:0] duty;
    logic [CH_NUM-1:0][PAT_W-1:0] pattern;
    logic [RCNT_W-1:0] rhythm_count, cnt0;
    logic [CH_NUM-1:0][15:0] lit, rises;
    int err_total, total_checks, events;
    int exp_lit[4] = '{0, 20, 40, 30};
    int exp_rise[4] = '{0, 10, 0, 5};

    pwm_pulse_rhythm_unit #(.RHYTHM_TICK_CYCLES(TK)) u_pwm_pulse_rhythm_unit (.clk, .nrst, .tick_fast,
        .tick_slow, .ch_enable, .src_fast, .prescale, .period, .duty, .invert, .mask_enable, .mask_level,
        .pattern, .sync_strobe, .sync_select, .rhythm_run, .rhythm_event_enable, .pwm_out, .rhythm_count,
        .rhythm_event);
    led_load u_led_load (.clk, .nrst, .clr, .drive(pwm_out), .lit, .rises);

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %0d exp %0d", $time, m, got, exp);
        end
    endtask

    // window of n edges; whole pattern or pwm periods keep the tallies exact whatever the phase
    task automatic win(input int n);
        @(negedge clk);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        events = 0;
        repeat (n) begin
            @(negedge clk);
            events += int'(rhythm_event);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, tick_fast, tick_slow, sync_strobe, rhythm_run, rhythm_event_enable, clr} = '0;
        {ch_enable, src_fast, invert, mask_enable, mask_level, sync_select} = '0;
        prescale = '0;
        period = '0;
        duty = '0;
        pattern = '1;
        repeat (20) @(negedge clk);
        chk(16'(pwm_out), 16'h0000, "reset out");
        chk(16'(rhythm_count), 16'h0013, "reset count");
        nrst = 1'b1;
        $display("test reset done");
        // mixed sources and duties: slow on 0 and 1, fast with prescaler on 2 and 3
        {tick_fast, tick_slow, ch_enable, src_fast, invert} = {2'b11, 4'hf, 4'hc, 4'h8};
        prescale = {4{12'h001}};
        period = {4{12'h003}};
        duty = {13'h0001, 13'h0005, 13'h0002, 13'h0000};
        repeat (16) @(negedge clk);
        win(40);
        for (int i = 0; i < CH_NUM; i++) begin
            chk(lit[i], 16'(exp_lit[i]), "lit cycles");
            chk(rises[i], 16'(exp_rise[i]), "turn-ons");
        end
        $display("test wave done");
        // put the channels out of step, then restart them together
        {src_fast, invert, ch_enable} = {4'h0, 4'h0, 4'h5};
        duty = {4{13'h0002}};
        @(negedge clk);
        ch_enable = 4'hf;
        repeat (3) @(negedge clk);
        {sync_strobe, sync_select} = {1'b1, 4'hf};
        @(negedge clk);
        sync_strobe = 1'b0;
        repeat (2) @(negedge clk);
        repeat (8) begin
            @(negedge clk);
            chk(16'(pwm_out ^ {4{pwm_out[0]}}), 16'h0000, "sync");
        end
        $display("test sync done");
        // masking: 0 held high outside count 0, 1 held low at count 0 only, 2 unmasked
        duty = {13'h0002, 13'h0005, 13'h1fff, 13'h0000};
        {mask_enable, mask_level, rhythm_run, rhythm_event_enable} = {4'h3, 4'h1, 2'b11};
        pattern = {20'hfffff, 20'h00000, 20'hffffe, 20'h00001};
        repeat (100) @(negedge clk);
        win(160);
        chk(lit[0], 16'd152, "mask high");
        chk(lit[1], 16'd152, "mask low");
        chk(lit[2], 16'd160, "unmasked");
        chk(16'(events), 16'h0002, "events");
        while (rhythm_event !== 1'b1 && events < 200) begin
            @(negedge clk);
            events++;
        end
        // a wait that runs out is a mismatch and ends the run
        if (rhythm_event !== 1'b1) begin
            chk(16'h0000, 16'h0001, "event wait timed out");
            close_out();
        end
        chk(16'(rhythm_count), 16'h0013, "wrap");
        repeat (3 * TK) @(negedge clk);
        chk(16'(rhythm_count), 16'h0010, "count down");
        rhythm_event_enable = 1'b0;
        win(160);
        chk(16'(events), 16'h0000, "event gated");
        rhythm_run = 1'b0;
        @(negedge clk);
        cnt0 = rhythm_count;
        repeat (40) @(negedge clk);
        chk(16'(rhythm_count), 16'(cnt0), "stopped");
        $display("test rhythm done");
        close_out();
    end
endmodule
